// *** hw/abfp_pkg.sv ***
package abfp_pkg;

    // ==========================================================
    // widths and reset values
    localparam int          DATA_W     = 8;
    localparam logic [7:0]  DATA_RST   = 8'h00;
    localparam logic        FLAG_IDLE  = 1'b1;   // inactive level of both flags
    localparam logic        OE_RST     = 1'b0;   // pins released in reset
    localparam logic        STROBE_RST = 1'b1;   // strobes idle high

    // ==========================================================
    // read-side sequencer states, one-hot
    typedef enum logic [1:0] {
        RD_IDLE  = 2'b01,
        RD_DRIVE = 2'b10
    } abfp_rd_e;

    // ==========================================================
    // one byte with its valid bit
    typedef struct packed {
        logic        valid;
        logic [7:0]  data;
    } abfp_byte_s;

    // edges of an active-low strobe
    typedef struct packed {
        logic fall;
        logic rise;
        logic low;
    } abfp_edge_s;

endpackage

// *** hw/abfp_strobe_edge.sv ***
module abfp_strobe_edge (
    input  wire logic               clk_sys,   // system clock
    input  wire logic               rst_n,     // synchronised reset, active low
    input  wire logic               strobe_n,  // active-low strobe, synchronous
    output abfp_pkg::abfp_edge_s    edges      // fall, rise and low level
);

    logic prev_ff;
    logic nxt_prev;

    // ==========================================================
    // previous level of the strobe
    always_comb begin
        nxt_prev = strobe_n;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= abfp_pkg::STROBE_RST;
        end else begin
            prev_ff <= nxt_prev;
        end
    end

    // edge terms against the previous level
    assign edges.fall = prev_ff & ~strobe_n;
    assign edges.rise = ~prev_ff & strobe_n;
    assign edges.low  = ~strobe_n;

endmodule

// *** hw/abfp_async_byte_fifo_port.sv ***
// What this block does
// - the port works as an asynchronous byte fifo only while the configuration memory selects that mode.
// - every byte transfer begins at a falling edge of the read or write strobe, with no interface clock.
// - the data bus is an input and is driven only while the read strobe is low.
// - the receive flag is low while a byte waits and high otherwise, and the host reads only while it is low.
// - after each read strobe returns high the receive flag goes high, and low again only for a further byte.
// - during reset both flags are left undriven so that they read as inactive high.
// - the transmit flag is low while a byte can be taken, and the host writes only while it is low.
// - a falling read strobe puts the current byte on the bus, a rising one fetches the next byte.
// - a falling write strobe while the transmit flag is low and the port is not driving the bus captures the byte on the bus into the transmit buffer.
// - while suspended with remote wakeup enabled, a low pulse on the wake input requests a resume.
// - while active, a low pulse on the wake input sends all buffered data on the next bulk-in request.
module abfp_async_byte_fifo_port (
    input  wire logic               clk_sys,            // system clock, 200 MHz
    input  wire logic               rst_n,              // reset, active low, asynchronous
    input  wire logic               mode_245_en,        // configuration selects byte fifo mode
    input  wire logic               rd_n,               // read strobe from host, active low
    input  wire logic               wr_n,               // write strobe from host, active low
    input  wire logic [7:0]         data_bus_in,        // data bus level seen at the pins
    output logic [7:0]              data_bus_out,       // data bus value when driven
    output logic                    data_bus_oe,        // data bus driven, active high
    output logic                    rx_available_n_out, // receive flag level, low = byte waits
    output logic                    rx_available_n_oe,  // receive flag driven
    output logic                    tx_space_n_out,     // transmit flag level, low = room
    output logic                    tx_space_n_oe,      // transmit flag driven
    input  wire logic               send_now_wake_n,    // send-now / wake input, active low
    input  wire logic               usb_active_n,       // low = usb active, high = suspended
    input  wire logic               remote_wake_en,     // remote wakeup allowed
    input  wire logic               bulk_in_req,        // bulk-in request served, one cycle
    input  abfp_pkg::abfp_byte_s    rx_byte,            // received byte offered by usb side
    output logic                    rx_ready,           // port takes rx_byte this cycle
    output abfp_pkg::abfp_byte_s    tx_byte,            // byte offered to usb side
    input  wire logic               tx_ready,           // usb side takes tx_byte
    output logic                    resume_req,         // resume request, one-cycle pulse
    output logic                    send_now_pend       // flush pending until bulk-in
);

    // ==========================================================
    // reset release through two flip-flops
    logic rst_meta_ff;
    logic rst_sync_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_n  <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_n  <= rst_meta_ff;
        end
    end

    // ==========================================================
    // strobe edges
    abfp_pkg::abfp_edge_s rd_e;
    abfp_pkg::abfp_edge_s wr_e;
    abfp_pkg::abfp_edge_s sw_e;

    abfp_strobe_edge u_rd_edge (
        .clk_sys  (clk_sys),
        .rst_n    (rst_sync_n),
        .strobe_n (rd_n),
        .edges    (rd_e)
    );

    abfp_strobe_edge u_wr_edge (
        .clk_sys  (clk_sys),
        .rst_n    (rst_sync_n),
        .strobe_n (wr_n),
        .edges    (wr_e)
    );

    abfp_strobe_edge u_sw_edge (
        .clk_sys  (clk_sys),
        .rst_n    (rst_sync_n),
        .strobe_n (send_now_wake_n),
        .edges    (sw_e)
    );

    // ==========================================================
    // mode capture after reset release
    logic mode_ff;
    logic nxt_mode;

    always_comb begin
        nxt_mode = mode_245_en;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ==========================================================
    // read side: holding byte, bus drive, receive flag
    abfp_pkg::abfp_rd_e     rd_st_ff;
    abfp_pkg::abfp_rd_e     nxt_rd_st;
    abfp_pkg::abfp_byte_s   rx_hold_ff;
    abfp_pkg::abfp_byte_s   nxt_rx_hold;
    logic [7:0]             data_out_ff;
    logic [7:0]             nxt_data_out;
    logic                   data_oe_ff;
    logic                   nxt_data_oe;
    logic                   rx_flag_ff;
    logic                   nxt_rx_flag;
    logic                   rx_ready_ff;
    logic                   nxt_rx_ready;
    logic                   flag_oe_ff;
    logic                   nxt_flag_oe;

    // read sequencer and fetch of the next byte
    always_comb begin
        nxt_rd_st    = rd_st_ff;
        nxt_rx_hold  = rx_hold_ff;
        nxt_data_out = data_out_ff;
        nxt_data_oe  = data_oe_ff;
        case (rd_st_ff)
            abfp_pkg::RD_IDLE: begin
                nxt_data_oe = 1'b0;
                if (mode_ff && rd_e.fall && rx_hold_ff.valid) begin
                    nxt_rd_st    = abfp_pkg::RD_DRIVE;
                    nxt_data_out = rx_hold_ff.data;
                    nxt_data_oe  = 1'b1;
                end
            end
            abfp_pkg::RD_DRIVE: begin
                if (!rd_e.low || !mode_ff) begin
                    nxt_rd_st         = abfp_pkg::RD_IDLE;
                    nxt_data_oe       = 1'b0;
                    nxt_rx_hold.valid = 1'b0;
                end
            end
            default: begin
                nxt_rd_st   = abfp_pkg::RD_IDLE;
                nxt_data_oe = 1'b0;
            end
        endcase
        if (rx_ready_ff && rx_byte.valid) begin
            nxt_rx_hold = rx_byte;
        end
        nxt_rx_flag  = ~nxt_rx_hold.valid;
        nxt_rx_ready = mode_ff & ~nxt_rx_hold.valid & (nxt_rd_st == abfp_pkg::RD_IDLE);
        nxt_flag_oe  = mode_ff;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_st_ff    <= abfp_pkg::RD_IDLE;
            rx_hold_ff  <= '0;
            data_out_ff <= abfp_pkg::DATA_RST;
            data_oe_ff  <= abfp_pkg::OE_RST;
            rx_flag_ff  <= abfp_pkg::FLAG_IDLE;
            rx_ready_ff <= 1'b0;
            flag_oe_ff  <= abfp_pkg::OE_RST;
        end else begin
            rd_st_ff    <= nxt_rd_st;
            rx_hold_ff  <= nxt_rx_hold;
            data_out_ff <= nxt_data_out;
            data_oe_ff  <= nxt_data_oe;
            rx_flag_ff  <= nxt_rx_flag;
            rx_ready_ff <= nxt_rx_ready;
            flag_oe_ff  <= nxt_flag_oe;
        end
    end

    // ==========================================================
    // write side: transmit holding byte and transmit flag
    abfp_pkg::abfp_byte_s   tx_hold_ff;
    abfp_pkg::abfp_byte_s   nxt_tx_hold;
    logic                   tx_flag_ff;
    logic                   nxt_tx_flag;

    // drain to usb side, then capture on the falling write strobe
    always_comb begin
        nxt_tx_hold = tx_hold_ff;
        if (tx_hold_ff.valid && tx_ready) begin
            nxt_tx_hold.valid = 1'b0;
        end
        // writes while the port drives the bus are ignored
        if (mode_ff && wr_e.fall && !tx_hold_ff.valid && !data_oe_ff) begin
            nxt_tx_hold.valid = 1'b1;
            nxt_tx_hold.data  = data_bus_in;
        end
        nxt_tx_flag = nxt_tx_hold.valid;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_hold_ff <= '0;
            tx_flag_ff <= abfp_pkg::FLAG_IDLE;
        end else begin
            tx_hold_ff <= nxt_tx_hold;
            tx_flag_ff <= nxt_tx_flag;
        end
    end

    // ==========================================================
    // send-now / wake input
    logic resume_ff;
    logic nxt_resume;
    logic pend_ff;
    logic nxt_pend;

    // resume while suspended, flush while active; a new pulse beats the clear
    always_comb begin
        nxt_resume = mode_ff & sw_e.fall & usb_active_n & remote_wake_en;
        nxt_pend   = pend_ff & ~bulk_in_req;
        if (mode_ff && sw_e.fall && !usb_active_n) begin
            nxt_pend = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            resume_ff <= 1'b0;
            pend_ff   <= 1'b0;
        end else begin
            resume_ff <= nxt_resume;
            pend_ff   <= nxt_pend;
        end
    end

    // ==========================================================
    // outputs straight from flip-flops
    assign data_bus_out       = data_out_ff;
    assign data_bus_oe        = data_oe_ff;
    assign rx_available_n_out = rx_flag_ff;
    assign rx_available_n_oe  = flag_oe_ff;
    assign tx_space_n_out     = tx_flag_ff;
    assign tx_space_n_oe      = flag_oe_ff;
    assign rx_ready           = rx_ready_ff;
    assign tx_byte            = tx_hold_ff;
    assign resume_req         = resume_ff;
    assign send_now_pend      = pend_ff;

    // ==========================================================
    // assertions
    a_mode_gates_pins: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        !mode_ff |=> !rx_available_n_oe && !tx_space_n_oe && !data_bus_oe)
        else $error("pins driven outside byte fifo mode");

    a_drive_needs_fall: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        $rose(data_bus_oe) |-> $past(rd_e.fall))
        else $error("bus drive began without a read strobe fall");

    a_drive_only_low: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        data_bus_oe |-> !$past(rd_n))
        else $error("bus driven while read strobe high");

    a_empty_read_ignored: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rd_e.fall && rx_available_n_out && !data_bus_oe |=> !data_bus_oe)
        else $error("read with flag high drove the bus");

    a_flag_high_after: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rd_st_ff == abfp_pkg::RD_DRIVE && rd_e.rise |=> rx_available_n_out && !data_bus_oe)
        else $error("receive flag not high after read strobe rose");

    a_flags_off_reset: assert property (@(posedge clk_sys)
        !rst_sync_n |-> !rx_available_n_oe && !tx_space_n_oe && !data_bus_oe)
        else $error("pins driven during reset");

    // flag level only matters once it is driven; its reset level is the idle high
    a_space_tracks_hold: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        tx_space_n_oe |-> tx_space_n_out == tx_byte.valid)
        else $error("transmit flag disagrees with buffer state");

    a_space_after_drain: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        tx_byte.valid && tx_ready |=> !tx_space_n_out && !tx_byte.valid)
        else $error("transmit flag not low after the byte left");

    a_full_write_dropped: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        tx_space_n_oe && wr_e.fall && tx_space_n_out && !tx_ready |=> $stable(tx_byte))
        else $error("write while full changed the buffer");

    a_byte_on_bus: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        mode_ff && rd_e.fall && !rx_available_n_out && rd_st_ff == abfp_pkg::RD_IDLE
        |=> data_bus_oe && data_bus_out == $past(rx_hold_ff.data))
        else $error("current byte not placed on the bus");

    a_write_capture: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        mode_ff && wr_e.fall && !tx_space_n_out && !data_bus_oe
        |=> tx_byte.valid && tx_byte.data == $past(data_bus_in) && tx_space_n_out)
        else $error("write strobe fall did not capture the bus");

    a_wake_resume: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        mode_ff && sw_e.fall && usb_active_n && remote_wake_en |=> resume_req ##1 !resume_req)
        else $error("wake pulse gave no single resume request");

    a_send_now: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        mode_ff && sw_e.fall && !usb_active_n |=> send_now_pend && !resume_req)
        else $error("send-now pulse not recorded");

    a_no_wake_disabled: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        sw_e.fall && !(usb_active_n && remote_wake_en) |=> !resume_req)
        else $error("resume requested while not allowed");

    // receive flag falls only when a new byte is taken in
    a_take_lowers_flag: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rx_ready && rx_byte.valid |=> !rx_available_n_out)
        else $error("receive flag not low with a byte waiting");

    a_flag_waits_byte: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rx_available_n_out && !(rx_ready && rx_byte.valid) |=> rx_available_n_out)
        else $error("receive flag fell with no byte taken");

endmodule

// *** bench/abfp_host_model.sv ***
module abfp_host_model (
    input  wire logic       clk_sys,        // system clock
    input  wire logic [7:0] dev_data,       // device bus value
    input  wire logic       dev_oe,         // device drives bus
    input  wire logic       rxf_out,        // receive flag value
    input  wire logic       rxf_oe,         // receive flag driven
    input  wire logic       txf_out,        // transmit flag value
    input  wire logic       txf_oe,         // transmit flag driven
    output logic            rd_n,           // read strobe
    output logic            wr_n,           // write strobe
    output logic [7:0]      bus,            // resolved data bus
    output logic            rx_available_n, // receive flag at pin
    output logic            tx_space_n      // transmit flag at pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] host_data = 8'h00;
    logic       host_oe = 1'b0;
    logic [7:0] last = 8'h00;
    // ==========================================================
    // wire resolution: flags pulled up, floating bus inverts
    assign rx_available_n = rxf_oe ? rxf_out : 1'b1;
    assign tx_space_n     = txf_oe ? txf_out : 1'b1;
    assign bus            = dev_oe ? dev_data : (host_oe ? host_data : ~last);
    // remember bus level at the last clock edge, driven or floating
    always @(posedge clk_sys) begin
        last <= bus;
    end
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
    end
    // ==========================================================
    // one read; skip_flag ignores the receive flag
    task automatic read_byte(input logic skip_flag, output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        d = 8'h00;
        while (!skip_flag && rx_available_n !== 1'b0 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        host_oe <= 1'b0;
        rd_n <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (dev_oe !== 1'b1 && n < 8);
        @(negedge clk_sys);
        ok = (n < 8);
        d = bus;
        @(posedge clk_sys);
        rd_n <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (dev_oe !== 1'b0 && n < 8);
    endtask
    // one write; skip_flag ignores the transmit flag
    task automatic write_byte(input logic [7:0] d, input logic skip_flag);
        int n;
        n = 0;
        while (!skip_flag && tx_space_n !== 1'b0 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        host_data <= d;
        host_oe <= 1'b1;
        wr_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        wr_n <= 1'b1;
        host_oe <= 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
endmodule

// *** bench/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 clk_sys, rst_n, mode_245_en, send_now_wake_n, usb_active_n;
    logic                 remote_wake_en, bulk_in_req, tx_ready, rd_n, wr_n, data_bus_oe;
    logic                 rxf_out, rxf_oe, txf_out, txf_oe, rx_ready, resume_req, send_now_pend;
    logic                 rx_available_n, tx_space_n;
    logic [7:0]           data_bus_in, data_bus_out;
    abfp_pkg::abfp_byte_s rx_byte, tx_byte;
    int                   n_errors = 0, num_checks = 0, n_resume = 0, n_cycles = 0;

    abfp_async_byte_fifo_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .mode_245_en(mode_245_en),
        .rd_n(rd_n), .wr_n(wr_n), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
        .data_bus_oe(data_bus_oe), .rx_available_n_out(rxf_out), .rx_available_n_oe(rxf_oe),
        .tx_space_n_out(txf_out), .tx_space_n_oe(txf_oe), .send_now_wake_n(send_now_wake_n),
        .usb_active_n(usb_active_n), .remote_wake_en(remote_wake_en), .bulk_in_req(bulk_in_req),
        .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .resume_req(resume_req), .send_now_pend(send_now_pend));
    abfp_host_model host (.clk_sys(clk_sys), .dev_data(data_bus_out), .dev_oe(data_bus_oe),
        .rxf_out(rxf_out), .rxf_oe(rxf_oe), .txf_out(txf_out), .txf_oe(txf_oe), .rd_n(rd_n),
        .wr_n(wr_n), .bus(data_bus_in), .rx_available_n(rx_available_n), .tx_space_n(tx_space_n));

    // ==========================================================
    // clock, resume pulse count, hang limit
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        n_resume <= n_resume + (resume_req === 1'b1);
        n_cycles <= n_cycles + 1;
        if (n_cycles == 5000) begin
            n_errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            conclude();
        end
    end
    task automatic expect_ok(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // offer one received byte until the port takes it
    task automatic offer_rx(input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        rx_byte <= '{valid: 1'b1, data: d};
        do begin
            @(negedge clk_sys);
            n++;
        end while (rx_ready !== 1'b1 && n < 60);
        @(posedge clk_sys);
        rx_byte <= '{valid: 1'b0, data: 8'h00};
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        expect_ok(rx_available_n === 1'b1 && tx_space_n === 1'b1 && data_bus_oe === 1'b0, "pins in reset");
        rst_n <= 1'b1;
        repeat (8) @(negedge clk_sys);
        expect_ok(rxf_oe === 1'b1 && rx_available_n === 1'b1 && tx_space_n === 1'b0, "flags after reset");
        $display("test reset done");
    endtask
    task automatic t_read();
        logic [7:0] d;
        logic       ok;
        offer_rx(8'hA5);
        fork
            offer_rx(8'h3C);
            begin
                host.read_byte(1'b0, d, ok);
                expect_ok(ok === 1'b1 && d === 8'hA5, "first byte");
                expect_ok(rx_available_n === 1'b1, "flag high after read");
                host.read_byte(1'b0, d, ok);
                expect_ok(ok === 1'b1 && d === 8'h3C, "second byte");
            end
        join
        repeat (3) @(negedge clk_sys);
        expect_ok(rx_available_n === 1'b1, "flag stays high when empty");
        host.read_byte(1'b1, d, ok);
        expect_ok(ok === 1'b0 && data_bus_oe === 1'b0, "empty read refused");
        $display("test read done");
    endtask
    task automatic t_write();
        host.write_byte(8'h5A, 1'b0);
        expect_ok(tx_byte.valid === 1'b1 && tx_byte.data === 8'h5A, "byte captured");
        expect_ok(tx_space_n === 1'b1, "tx flag full");
        host.write_byte(8'hC3, 1'b1);
        expect_ok(tx_byte.data === 8'h5A, "write while full dropped");
        @(posedge clk_sys);
        tx_ready <= 1'b1;
        @(posedge clk_sys);
        tx_ready <= 1'b0;
        repeat (2) @(negedge clk_sys);
        expect_ok(tx_byte.valid === 1'b0 && tx_space_n === 1'b0, "tx drained");
        $display("test write done");
    endtask
    task automatic pulse_wake(input logic susp, input logic wen);
        @(posedge clk_sys);
        usb_active_n <= susp;
        remote_wake_en <= wen;
        @(posedge clk_sys);
        send_now_wake_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        send_now_wake_n <= 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic t_wake();
        pulse_wake(1'b1, 1'b1);
        expect_ok(n_resume == 1 && send_now_pend === 1'b0, "resume requested");
        pulse_wake(1'b1, 1'b0);
        expect_ok(n_resume == 1, "no resume without wake enable");
        pulse_wake(1'b0, 1'b1);
        expect_ok(send_now_pend === 1'b1 && n_resume == 1, "flush pending");
        @(posedge clk_sys);
        bulk_in_req <= 1'b1;
        @(posedge clk_sys);
        bulk_in_req <= 1'b0;
        @(negedge clk_sys);
        expect_ok(send_now_pend === 1'b0, "flush served");
        $display("test wake done");
    endtask
    task automatic t_mode();
        logic [7:0] d;
        logic       ok;
        @(posedge clk_sys);
        mode_245_en <= 1'b0;
        repeat (4) @(negedge clk_sys);
        expect_ok(rxf_oe === 1'b0 && txf_oe === 1'b0 && tx_space_n === 1'b1, "flags off");
        host.read_byte(1'b1, d, ok);
        host.write_byte(8'h77, 1'b1);
        expect_ok(ok === 1'b0 && tx_byte.valid === 1'b0, "strobes ignored");
        @(posedge clk_sys);
        mode_245_en <= 1'b1;
        repeat (4) @(negedge clk_sys);
        expect_ok(rxf_oe === 1'b1 && tx_space_n === 1'b0, "mode back on");
        $display("test mode done");
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        mode_245_en = 1'b1;
        send_now_wake_n = 1'b1;
        usb_active_n = 1'b0;
        remote_wake_en = 1'b0;
        bulk_in_req = 1'b0;
        tx_ready = 1'b0;
        rx_byte = '0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_read();
        t_write();
        t_wake();
        t_mode();
        conclude();
    end
endmodule
